// *** src/nand_param_status_host.sv ***
// Host sequencer reading the NAND parameter page and polling status.
//
// Behaviour
// - Bytes 254-255 hold the page check.
// - Check uses polynomial 8005h.
// - Seed 4F4Eh, no reflection, no final XOR.
// - Send 00h before resuming data reads.
`timescale 1ns/1ns
module nand_param_status_host #(
   parameter int TICK_DIV = nand_host_pkg::STROBE_CYC
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   // User orders, one-cycle pulses.
   input wire logic param_start,
   input wire logic status_start,
   input wire logic resume_start,
   input wire logic poll_stop,
   // User results.
   output logic busy,
   output logic param_done,
   output logic param_crc_ok,
   output logic param_field_err,
   output nand_host_pkg::param_fields_t param_fields,
   output nand_host_pkg::nand_status_t status,
   output logic status_valid,
   output logic op_fail_valid,
   output logic status_incoherent,
   // Flash pins.
   output nand_host_pkg::nand_ctl_t ctl,
   output logic [7:0] dq_out,
   output logic dq_oe_n,
   input wire logic [7:0] dq_in,
   input wire logic rb_n
);
   import nand_host_pkg::*;

   typedef enum logic [2:0] {
      S_IDLE, S_SEND_LO, S_SEND_HI, S_BUSY_WAIT, S_RDY_WAIT, S_RD_LO,
      S_RD_HI, S_POLL
   } state_t;

   localparam nand_ctl_t CTL_IDLE = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};

   // Two-stage synchronisers for the asynchronous pins.
   logic [7:0] dq_m_q, dq_s_q;
   logic rb_m_q, rb_s_q;

   // Strobe pacing divider.
   logic [7:0] div_q, div_d;
   logic tick_q, tick_d;

   // Sequencer state.
   state_t state_q, state_d;
   nand_ctl_t ctl_q, ctl_d;
   logic [7:0] dq_out_q, dq_out_d;
   logic oe_n_q, oe_n_d;
   logic [7:0] byte_q, byte_d;
   logic [1:0] copy_q, copy_d;
   logic [3:0] wait_q, wait_d;
   logic [7:0] crc_lo_q, crc_lo_d;
   param_fields_t fields_q, fields_d;
   logic field_err_q, field_err_d;
   logic crc_ok_q, crc_ok_d;
   logic done_q, done_d;
   nand_status_t status_q, status_d;
   logic stat_valid_q, stat_valid_d;
   logic fail_valid_q, fail_valid_d;
   logic incoh_q, incoh_d;
   logic busy_q, busy_d;

   // Check engine hookup.
   logic crc_init, crc_en;
   logic [15:0] crc_val;

   // Expected page byte; bit 8 marks a checked byte.
   function automatic logic [8:0] byte_expect(input logic [7:0] idx);
      logic [8:0] r;
      r = 9'h000;
      case (idx)
         OFS_TIMING, OFS_CACHE_TIMING: r = {1'b1, EXP_TIMING_MODES[7:0]};
         OFS_TIMING + 8'h01, OFS_CACHE_TIMING + 8'h01:
            r = {1'b1, EXP_TIMING_MODES[15:8]};
         OFS_PROG_TIME: r = {1'b1, EXP_WRITE_TIME[7:0]};
         OFS_PROG_TIME + 8'h01: r = {1'b1, EXP_WRITE_TIME[15:8]};
         OFS_ERASE_TIME: r = {1'b1, EXP_WIPE_TIME[7:0]};
         OFS_ERASE_TIME + 8'h01: r = {1'b1, EXP_WIPE_TIME[15:8]};
         OFS_LOAD_TIME: r = {1'b1, EXP_LOAD_TIME[7:0]};
         OFS_LOAD_TIME + 8'h01: r = {1'b1, EXP_LOAD_TIME[15:8]};
         OFS_CCS_TIME: r = {1'b1, EXP_CCS_TIME[7:0]};
         OFS_CCS_TIME + 8'h01: r = {1'b1, EXP_CCS_TIME[15:8]};
         default: begin
            // Reserved and vendor bytes must all be zero.
            if (idx >= OFS_ZERO_LO && idx <= OFS_ZERO_HI) begin
               r = 9'h100;
            end
         end
      endcase
      return r;
   endfunction

   param_crc16 u_crc (
      .clock(clock),
      .rst_n(rst_n),
      .init(crc_init),
      .en(crc_en),
      .data(dq_s_q),
      .crc(crc_val)
   );

   // Pin synchronisers; only the second stage is read by logic.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         dq_m_q <= 8'h00;
         dq_s_q <= 8'h00;
         rb_m_q <= 1'b0;
         rb_s_q <= 1'b0;
      end else begin
         dq_m_q <= dq_in;
         dq_s_q <= dq_m_q;
         rb_m_q <= rb_n;
         rb_s_q <= rb_m_q;
      end
   end

   // Divider producing one tick every TICK_DIV cycles.
   always_comb begin
      tick_d = 1'b0;
      div_d = div_q + 8'h01;
      if (div_q == 8'(TICK_DIV - 1)) begin
         div_d = 8'h00;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         div_q <= 8'h00;
         tick_q <= 1'b0;
      end else begin
         div_q <= div_d;
         tick_q <= tick_d;
      end
   end

   // Sequencer next-state logic.
   always_comb begin
      logic [8:0] exp;
      logic launch;
      exp = byte_expect(byte_q);
      launch = param_start | status_start | resume_start;
      state_d = state_q;
      ctl_d = ctl_q;
      dq_out_d = dq_out_q;
      oe_n_d = oe_n_q;
      byte_d = byte_q;
      copy_d = copy_q;
      wait_d = wait_q;
      crc_lo_d = crc_lo_q;
      fields_d = fields_q;
      field_err_d = field_err_q;
      crc_ok_d = crc_ok_q;
      done_d = 1'b0;
      status_d = status_q;
      stat_valid_d = stat_valid_q;
      fail_valid_d = fail_valid_q;
      incoh_d = incoh_q;
      crc_init = 1'b0;
      crc_en = 1'b0;
      // A new order is taken when idle, and also ends status mode.
      if ((state_q == S_IDLE || state_q == S_POLL) && launch) begin
         state_d = S_SEND_LO;
         ctl_d = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
         oe_n_d = 1'b0;
         stat_valid_d = 1'b0;
         if (param_start) begin
            dq_out_d = CMD_PARAM_PAGE;
         end else if (status_start) begin
            dq_out_d = CMD_READ_STATUS;
         end else begin
            // Reads after a poll restart with this command.
            dq_out_d = CMD_READ_RESUME;
         end
      end else begin
         case (state_q)
            S_IDLE: begin
               ctl_d = CTL_IDLE;
               oe_n_d = 1'b1;
            end
            S_SEND_LO: begin
               // Write strobe rises, latching the byte.
               if (tick_q) begin
                  ctl_d.we_n = 1'b1;
                  state_d = S_SEND_HI;
               end
            end
            S_SEND_HI: begin
               if (tick_q) begin
                  ctl_d.cle = 1'b0;
                  ctl_d.ale = 1'b0;
                  oe_n_d = 1'b1;
                  if (ctl_q.cle && dq_out_q == CMD_PARAM_PAGE) begin
                     // Page read needs one address byte.
                     ctl_d.ale = 1'b1;
                     ctl_d.we_n = 1'b0;
                     oe_n_d = 1'b0;
                     dq_out_d = ADDR_PARAM;
                     state_d = S_SEND_LO;
                  end else if (ctl_q.ale) begin
                     wait_d = 4'(BUSY_WAIT_TICKS);
                     state_d = S_BUSY_WAIT;
                  end else if (dq_out_q == CMD_READ_STATUS) begin
                     // Read strobe falls after chip select is low.
                     ctl_d.read_strobe_n = 1'b0;
                     state_d = S_POLL;
                  end else begin
                     ctl_d = CTL_IDLE;
                     state_d = S_IDLE;
                  end
               end
            end
            S_BUSY_WAIT: begin
               // Give the busy line time to fall before watching it.
               if (tick_q) begin
                  wait_d = wait_q - 4'h1;
                  if (wait_q == 4'h1) begin
                     state_d = S_RDY_WAIT;
                  end
               end
            end
            S_RDY_WAIT: begin
               if (rb_s_q && tick_q) begin
                  byte_d = 8'h00;
                  copy_d = 2'h0;
                  field_err_d = 1'b0;
                  crc_ok_d = 1'b0;
                  crc_init = 1'b1;
                  ctl_d.read_strobe_n = 1'b0;
                  wait_d = 4'h2;
                  state_d = S_RD_LO;
               end
            end
            S_RD_LO: begin
               // Hold the strobe low past the two-stage lag, so the
               // sampled byte is the one the flash now drives.
               if (wait_q != 4'h0) begin
                  wait_d = wait_q - 4'h1;
               end
               if (tick_q && wait_q == 4'h0) begin
                  ctl_d.read_strobe_n = 1'b1;
                  state_d = S_RD_HI;
                  crc_en = byte_q < OFS_CRC_LO;
                  if (exp[8] && dq_s_q != exp[7:0]) begin
                     field_err_d = 1'b1;
                  end
                  case (byte_q)
                     OFS_TIMING: fields_d.timing_modes[7:0] = dq_s_q;
                     OFS_TIMING + 8'h01:
                        fields_d.timing_modes[15:8] = dq_s_q;
                     OFS_CACHE_TIMING:
                        fields_d.cache_timing_modes[7:0] = dq_s_q;
                     OFS_CACHE_TIMING + 8'h01:
                        fields_d.cache_timing_modes[15:8] = dq_s_q;
                     OFS_PROG_TIME:
                        fields_d.page_write_time_max[7:0] = dq_s_q;
                     OFS_PROG_TIME + 8'h01:
                        fields_d.page_write_time_max[15:8] = dq_s_q;
                     OFS_ERASE_TIME:
                        fields_d.block_wipe_time_max[7:0] = dq_s_q;
                     OFS_ERASE_TIME + 8'h01:
                        fields_d.block_wipe_time_max[15:8] = dq_s_q;
                     OFS_LOAD_TIME:
                        fields_d.page_load_time_max[7:0] = dq_s_q;
                     OFS_LOAD_TIME + 8'h01:
                        fields_d.page_load_time_max[15:8] = dq_s_q;
                     OFS_CCS_TIME:
                        fields_d.column_change_setup_min[7:0] = dq_s_q;
                     OFS_CCS_TIME + 8'h01:
                        fields_d.column_change_setup_min[15:8] = dq_s_q;
                     OFS_CRC_LO: crc_lo_d = dq_s_q;
                     OFS_CRC_HI:
                        crc_ok_d = {dq_s_q, crc_lo_q} == crc_val;
                     default: begin
                     end
                  endcase
               end
            end
            S_RD_HI: begin
               if (tick_q) begin
                  byte_d = byte_q + 8'h01;
                  ctl_d.read_strobe_n = 1'b0;
                  wait_d = 4'h2;
                  state_d = S_RD_LO;
                  if (byte_q == OFS_CRC_HI) begin
                     if (crc_ok_q) begin
                        done_d = 1'b1;
                        ctl_d = CTL_IDLE;
                        state_d = S_IDLE;
                     end else if (copy_q == COPIES_LAST) begin
                        done_d = 1'b1;
                        ctl_d = CTL_IDLE;
                        state_d = S_IDLE;
                     end else begin
                        // A bad copy falls through to the next one.
                        copy_d = copy_q + 2'h1;
                        crc_init = 1'b1;
                        field_err_d = 1'b0;
                     end
                  end
               end
            end
            S_POLL: begin
               // Strobes stay low; the device keeps the byte current.
               stat_valid_d = 1'b1;
               status_d = dq_s_q;
               fail_valid_d = dq_s_q[5];
               if (!dq_s_q[6] && dq_s_q[5]) begin
                  incoh_d = 1'b1;
               end
               if (poll_stop) begin
                  ctl_d = CTL_IDLE;
                  stat_valid_d = 1'b0;
                  state_d = S_IDLE;
               end
            end
            default: begin
               ctl_d = CTL_IDLE;
               state_d = S_IDLE;
            end
         endcase
      end
      busy_d = state_d != S_IDLE;
   end

   // Sequencer registers.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= S_IDLE;
         ctl_q <= CTL_IDLE;
         dq_out_q <= 8'h00;
         oe_n_q <= 1'b1;
         byte_q <= 8'h00;
         copy_q <= 2'h0;
         wait_q <= 4'h0;
         crc_lo_q <= 8'h00;
         fields_q <= '0;
         field_err_q <= 1'b0;
         crc_ok_q <= 1'b0;
         done_q <= 1'b0;
         status_q <= '0;
         stat_valid_q <= 1'b0;
         fail_valid_q <= 1'b0;
         incoh_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         state_q <= state_d;
         ctl_q <= ctl_d;
         dq_out_q <= dq_out_d;
         oe_n_q <= oe_n_d;
         byte_q <= byte_d;
         copy_q <= copy_d;
         wait_q <= wait_d;
         crc_lo_q <= crc_lo_d;
         fields_q <= fields_d;
         field_err_q <= field_err_d;
         crc_ok_q <= crc_ok_d;
         done_q <= done_d;
         status_q <= status_d;
         stat_valid_q <= stat_valid_d;
         fail_valid_q <= fail_valid_d;
         incoh_q <= incoh_d;
         busy_q <= busy_d;
      end
   end

   assign busy = busy_q;
   assign param_done = done_q;
   assign param_crc_ok = crc_ok_q;
   assign param_field_err = field_err_q;
   assign param_fields = fields_q;
   assign status = status_q;
   assign status_valid = stat_valid_q;
   assign op_fail_valid = fail_valid_q;
   assign status_incoherent = incoh_q;
   assign ctl = ctl_q;
   assign dq_out = dq_out_q;
   assign dq_oe_n = oe_n_q;
endmodule

// *** src/nand_host_pkg.sv ***
// Constants and carrier types shared by the NAND parameter/status host.
package nand_host_pkg;

   // Command and address bytes placed on the data lines.
   localparam logic [7:0] CMD_PARAM_PAGE = 8'hEC;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_READ_RESUME = 8'h00;
   localparam logic [7:0] ADDR_PARAM = 8'h00;

   // Parameter page layout; byte offsets within one 256-byte copy.
   localparam int PAGE_BYTES = 256;
   localparam logic [1:0] COPIES_LAST = 2'h2;
   localparam logic [7:0] OFS_TIMING = 8'h81;
   localparam logic [7:0] OFS_CACHE_TIMING = 8'h83;
   localparam logic [7:0] OFS_PROG_TIME = 8'h85;
   localparam logic [7:0] OFS_ERASE_TIME = 8'h87;
   localparam logic [7:0] OFS_LOAD_TIME = 8'h89;
   localparam logic [7:0] OFS_CCS_TIME = 8'h8B;
   localparam logic [7:0] OFS_ZERO_LO = 8'h8D;
   localparam logic [7:0] OFS_ZERO_HI = 8'hFD;
   localparam logic [7:0] OFS_CRC_LO = 8'hFE;
   localparam logic [7:0] OFS_CRC_HI = 8'hFF;

   // Values the device is expected to report, low byte first.
   localparam logic [15:0] EXP_TIMING_MODES = 16'h003F;
   localparam logic [15:0] EXP_WRITE_TIME = 16'h0258;
   localparam logic [15:0] EXP_WIPE_TIME = 16'h2710;
   localparam logic [15:0] EXP_LOAD_TIME = 16'h0019;
   localparam logic [15:0] EXP_CCS_TIME = 16'h0050;

   // Integrity check polynomial and seed.
   localparam logic [15:0] CRC_POLY = 16'h8005;
   localparam logic [15:0] CRC_SEED = 16'h4F4E;

   // Strobe pacing: each strobe phase waits for a divider tick; a read-low phase also waits out two cycles of lag.
   localparam int CLOCK_NS = 100;
   localparam int STROBE_NS = 200;
   localparam int STROBE_CYC = (STROBE_NS + CLOCK_NS - 1) / CLOCK_NS;
   localparam int BUSY_WAIT_NS = 1000;
   localparam int BUSY_WAIT_TICKS = (BUSY_WAIT_NS + STROBE_NS - 1) / STROBE_NS;

   // Control strobes driven toward the flash.
   typedef struct packed {
      logic ce_n;
      logic cle;
      logic ale;
      logic we_n;
      logic read_strobe_n;
   } nand_ctl_t;

   // Status byte, bit 7 first.
   typedef struct packed {
      logic not_protected;
      logic ready;
      logic array_idle_flag;
      logic [2:0] unused;
      logic prior_page_result_flag;
      logic op_fail;
   } nand_status_t;

   // Parameter fields kept after a page read.
   typedef struct packed {
      logic [15:0] timing_modes;
      logic [15:0] cache_timing_modes;
      logic [15:0] page_write_time_max;
      logic [15:0] block_wipe_time_max;
      logic [15:0] page_load_time_max;
      logic [15:0] column_change_setup_min;
   } param_fields_t;

endpackage

// *** src/param_crc16.sv ***
// Byte-serial CRC-16 engine for the parameter page check.
`timescale 1ns/1ns
module param_crc16 (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   // Byte stream.
   input wire logic init,
   input wire logic en,
   input wire logic [7:0] data,
   // Running check value.
   output logic [15:0] crc
);
   import nand_host_pkg::*;

   logic [15:0] crc_q;
   logic [15:0] crc_d;

   // Shift the byte in most significant bit first, no reflection.
   always_comb begin
      crc_d = crc_q;
      if (init) begin
         crc_d = CRC_SEED;
      end else if (en) begin
         for (int i = 7; i >= 0; i--) begin
            if (crc_d[15] ^ data[i]) begin
               crc_d = {crc_d[14:0], 1'b0} ^ CRC_POLY;
            end else begin
               crc_d = {crc_d[14:0], 1'b0};
            end
         end
      end
   end

   // Register the running value.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         crc_q <= CRC_SEED;
      end else begin
         crc_q <= crc_d;
      end
   end

   assign crc = crc_q;
endmodule

// *** tb/nand_host_properties.sv ***
// Port checker for the host sequencer.
`timescale 1ns/1ns
module nand_host_checker (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   // User side.
   input wire logic param_start,
   input wire logic status_start,
   input wire logic resume_start,
   input wire logic poll_stop,
   input wire logic busy,
   input wire logic param_done,
   input wire logic param_crc_ok,
   input wire nand_host_pkg::param_fields_t param_fields,
   input wire nand_host_pkg::nand_status_t status,
   input wire logic status_valid,
   input wire logic op_fail_valid,
   // Flash side.
   input wire nand_host_pkg::nand_ctl_t ctl,
   input wire logic [7:0] dq_out,
   input wire logic dq_oe_n,
   input wire logic [7:0] dq_in
);
   import nand_host_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Both bitmaps of an accepted page, low byte first.
   property p_modes;
      param_done && param_crc_ok |-> param_fields[95:64] == 32'h003F003F;
   endproperty
   a_modes: assert property (p_modes)
      else $error("bitmaps wrong");
   // Four time fields of an accepted page.
   property p_times;
      param_done && param_crc_ok |->
         param_fields[63:0] == 64'h0258271000190050;
   endproperty
   a_times: assert property (p_times)
      else $error("times wrong");
   // A page read opens with its command.
   property p_param_cmd;
      param_start && !busy |=> ctl.cle && !ctl.ce_n && !ctl.we_n
         && !dq_oe_n && dq_out == 8'hEC;
   endproperty
   a_param_cmd: assert property (p_param_cmd)
      else $error("no page command");
   // A poll opens with the status command.
   property p_status_cmd;
      status_start && !param_start && !busy |=> ctl.cle && !ctl.ce_n
         && !dq_oe_n && dq_out == 8'h70;
   endproperty
   a_status_cmd: assert property (p_status_cmd)
      else $error("no status command");
   // Resuming reads sends the read command.
   property p_resume_cmd;
      resume_start && !param_start && !status_start && (!busy || status_valid)
         |=> ctl.cle && !dq_oe_n && dq_out == 8'h00;
   endproperty
   a_resume_cmd: assert property (p_resume_cmd)
      else $error("no read command");
   // Polling holds strobes low, lines free.
   property p_poll_pins;
      status_valid |-> !ctl.ce_n && !ctl.read_strobe_n && !ctl.cle
         && !ctl.ale && dq_oe_n;
   endproperty
   a_poll_pins: assert property (p_poll_pins)
      else $error("poll strobes moved");
   // Polling ends only on a new order or a poll stop.
   property p_poll_holds;
      status_valid && !(param_start || status_start || resume_start
         || poll_stop) |=> status_valid;
   endproperty
   a_poll_holds: assert property (p_poll_holds)
      else $error("poll ended on its own");
   // Steady lines reach status after the lag.
   property p_status_track;
      (status_valid && $stable(dq_in)) [*4] |-> status == dq_in;
   endproperty
   a_status_track: assert property (p_status_track)
      else $error("status stale");
   // Fail qualifier follows array idle.
   property p_op_fail;
      status_valid |-> op_fail_valid == status.array_idle_flag;
   endproperty
   a_op_fail: assert property (p_op_fail)
      else $error("qualifier wrong");
   // No driving while the read strobe is low.
   property p_no_fight;
      !dq_oe_n |-> ctl.read_strobe_n;
   endproperty
   a_no_fight: assert property (p_no_fight)
      else $error("line contention");
   // Completion is a single cycle pulse.
   property p_done_pulse;
      param_done |=> !param_done;
   endproperty
   a_done_pulse: assert property (p_done_pulse)
      else $error("done too long");
endmodule
bind nand_param_status_host nand_host_checker u_checker (
   .clock(clock), .rst_n(rst_n), .param_start(param_start),
   .status_start(status_start), .resume_start(resume_start),
   .poll_stop(poll_stop), .busy(busy), .param_done(param_done),
   .param_crc_ok(param_crc_ok), .param_fields(param_fields),
   .status(status), .status_valid(status_valid),
   .op_fail_valid(op_fail_valid), .ctl(ctl), .dq_out(dq_out),
   .dq_oe_n(dq_oe_n), .dq_in(dq_in));

// *** tb/nand_flash_model.sv ***
// Flash model answering page and status reads.
`timescale 1ns/1ns
module nand_flash_model #(
   parameter int LOAD_NS = 25000
) (
   // Pins from the host.
   input wire nand_host_pkg::nand_ctl_t ctl,
   input wire logic [7:0] dq_out,
   // Pins to the host.
   output logic [7:0] dq_in,
   output logic rb_n,
   // Scenario controls.
   input wire logic [7:0] status_in,
   input wire logic [2:0] bad_crc,
   input wire logic rsv_err
);
   import nand_host_pkg::*;
   logic [7:0] cmd_q = 8'h00; // Last command taken.
   logic [1:0] mode_q = 2'h0; // 0 released, 1 page out, 2 status out.
   int idx_q = 0; // Next page byte.
   logic [7:0] last_q = 8'h5A; // Shown inverted when released.
   logic [7:0] stat; // Status as reported.
   initial rb_n = 1'b1;
   // Page byte; lower bytes ramp.
   function automatic logic [7:0] raw_byte(input int ofs);
      case (ofs)
         129, 131: return 8'h3F;
         130, 132, 138, 140: return 8'h00;
         133: return 8'h58;
         134: return 8'h02;
         135: return 8'h10;
         136: return 8'h27;
         137: return 8'h19;
         139: return 8'h50;
         150: return {7'h00, rsv_err};
         default: return (ofs < 129) ? 8'(ofs + 1) : 8'h00;
      endcase
   endfunction
   // Check over bytes 0-253, MSB first.
   function automatic logic [15:0] page_crc();
      logic [15:0] c;
      logic [7:0] b;
      c = 16'h4F4E;
      for (int i = 0; i < 254; i++) begin
         b = raw_byte(i);
         for (int k = 7; k >= 0; k--) begin
            c = {c[14:0], 1'b0} ^ (c[15] ^ b[k] ? 16'h8005 : 16'h0);
         end
      end
      return c;
   endfunction
   // Byte at an address; a copy may spoil its check.
   function automatic logic [7:0] page_byte(input int a);
      logic [15:0] c;
      logic flip;
      c = page_crc();
      flip = (a < 768) ? bad_crc[2'(a / 256)] : 1'b0;
      if (a % 256 == 254) begin
         return c[7:0] ^ {7'h00, flip};
      end else if (a % 256 == 255) begin
         return c[15:8];
      end
      return raw_byte(a % 256);
   endfunction
   // Commands and addresses latch on write strobe rise.
   always @(posedge ctl.we_n) begin
      if (!ctl.ce_n && ctl.cle) begin
         cmd_q = dq_out;
         mode_q = (dq_out == CMD_READ_STATUS) ? 2'h2 : 2'h0;
      end else if (!ctl.ce_n && ctl.ale && cmd_q == CMD_PARAM_PAGE) begin
         idx_q = 0;
         rb_n = 1'b0;
         #(LOAD_NS) rb_n = 1'b1;
         mode_q = 2'h1;
      end
   end
   // Each page read cycle advances the byte.
   always @(posedge ctl.read_strobe_n) begin
      last_q = dq_in;
      if (mode_q == 2'h1) begin
         idx_q = idx_q + 1;
      end
   end
   // A busy command hides the array idle bit.
   always_comb begin
      stat = status_in;
      if (!status_in[6]) begin
         stat[5] = 1'b0;
      end
   end
   // Drives from the later strobe fall, kept live.
   always_comb begin
      if (ctl.ce_n || ctl.read_strobe_n || mode_q == 2'h0) begin
         dq_in = ~last_q;
      end else if (mode_q == 2'h2) begin
         dq_in = stat;
      end else begin
         dq_in = page_byte(idx_q);
      end
   end
endmodule

// *** tb/tb.sv ***
// Bench for the page and status host.
`timescale 1ns/1ns
module tb;
   import nand_host_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic param_start = 1'b0;
   logic status_start = 1'b0;
   logic resume_start = 1'b0;
   logic poll_stop = 1'b0;
   logic busy, param_done, param_crc_ok, param_field_err;
   logic status_valid, op_fail_valid, status_incoherent, dq_oe_n, rb_n;
   param_fields_t param_fields;
   nand_status_t status;
   nand_ctl_t ctl;
   logic [7:0] dq_out, dq_in;
   logic [7:0] status_in = 8'hE0; // Status to report.
   logic [2:0] bad_crc = 3'h0; // Copies with a spoiled check.
   logic rsv_err = 1'b0; // Spoils a reserved byte.
   int mismatches = 0;
   int checks = 0;
   // Status rows: byte driven, byte reported.
   typedef struct packed {
      logic [7:0] drive;
      logic [7:0] seen;
   } row_t;
   localparam row_t ROWS [7] = '{'{8'hE0, 8'hE0}, '{8'h60, 8'h60},
      '{8'hE1, 8'hE1}, '{8'hE2, 8'hE2}, '{8'h80, 8'h80},
      '{8'hA0, 8'h80}, '{8'hC3, 8'hC3}};
   always #50 clock = ~clock;
   nand_param_status_host #(.TICK_DIV(2)) DUT (.clock(clock), .rst_n(rst_n),
      .param_start(param_start), .status_start(status_start),
      .resume_start(resume_start), .poll_stop(poll_stop), .busy(busy),
      .param_done(param_done), .param_crc_ok(param_crc_ok),
      .param_field_err(param_field_err), .param_fields(param_fields),
      .status(status), .status_valid(status_valid),
      .op_fail_valid(op_fail_valid), .status_incoherent(status_incoherent),
      .ctl(ctl), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in),
      .rb_n(rb_n));
   nand_flash_model flash (.ctl(ctl), .dq_out(dq_out), .dq_in(dq_in),
      .rb_n(rb_n), .status_in(status_in), .bad_crc(bad_crc),
      .rsv_err(rsv_err));
   // Four-state compare, so unknowns never match.
   task automatic check(input logic [15:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   // Counts, verdict, end.
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // One-cycle order pulse.
   task automatic pulse(input int which);
      @(posedge clock);
      #10;
      case (which)
         0: param_start = 1'b1;
         1: status_start = 1'b1;
         2: resume_start = 1'b1;
         default: poll_stop = 1'b1;
      endcase
      @(posedge clock);
      #10;
      {param_start, status_start, resume_start, poll_stop} = 4'h0;
   endtask
   // Bounded wait for done, poll or idle.
   task automatic wait_for(input int which, input int lim);
      int n = 0;
      logic hit = 1'b0;
      while (hit !== 1'b1 && n < lim) begin
         @(posedge clock);
         #10;
         n++;
         hit = which == 0 ? param_done : which == 1 ? status_valid : !busy;
      end
      check(16'(hit === 1'b1), 16'h0001);
   endtask
   // Page read with copies spoiled as ordered.
   task automatic read_page(input logic [2:0] bad, input logic rerr,
      input logic ok);
      bad_crc = bad;
      rsv_err = rerr;
      pulse(0);
      wait_for(0, 6000);
      check(param_crc_ok, ok);
      if (ok) begin
         check(param_field_err, rerr);
         check(param_fields.block_wipe_time_max, 16'h2710);
      end
   endtask
   // Reads take under 6,000 cycles each.
   initial begin
      repeat (60000) @(posedge clock);
      mismatches++;
      conclude();
   end
   initial begin
      repeat (8) @(posedge clock);
      #10;
      rst_n = 1'b1;
      // All rows in one poll, no strobe re-toggled.
      pulse(1);
      wait_for(1, 100);
      foreach (ROWS[i]) begin
         status_in = ROWS[i].drive;
         repeat (8) @(posedge clock);
         #10;
         check(status, ROWS[i].seen);
         check(op_fail_valid, ROWS[i].seen[5]);
      end
      check(status_incoherent, 1'b0);
      pulse(3);
      wait_for(2, 20);
      check(status_valid, 1'b0);
      pulse(1);
      wait_for(1, 100);
      pulse(2);
      wait_for(2, 100);
      check(status_valid, 1'b0);
      read_page(3'h0, 1'b0, 1'b1);
      read_page(3'h3, 1'b0, 1'b1);
      read_page(3'h7, 1'b0, 1'b0);
      read_page(3'h0, 1'b1, 1'b1);
      // A status order in mid-read is ignored.
      pulse(0);
      repeat (20) @(posedge clock);
      pulse(1);
      wait_for(0, 6000);
      check(status_valid, 1'b0);
      check(param_crc_ok, 1'b1);
      // Reset mid-read idles the strobes at once.
      pulse(0);
      repeat (40) @(posedge clock);
      #30;
      rst_n = 1'b0;
      #20;
      check(busy, 1'b0);
      check(ctl, 16'h0013);
      check(dq_oe_n, 1'b1);
      repeat (8) @(posedge clock);
      #10;
      rst_n = 1'b1;
      repeat (2) @(posedge clock);
      check(busy, 1'b0);
      conclude();
   end
endmodule
